// ---- bench/ebp_bus_master.sv ----
`timescale 1ns/1ns
// Processor bus master model: classic single Wishbone cycles
module ebp_bus_master (
  // Clock
  input wire logic clk_i,
  // Wishbone master side
  output logic wb_cyc_o,
  output logic wb_stb_o,
  output logic wb_we_o,
  output logic [7:0] wb_adr_o,
  output logic [3:0] wb_sel_o,
  output logic [31:0] wb_dat_o,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_i
);
  // Idle bus at time zero
  initial begin
    wb_cyc_o = 1'b0;
    wb_stb_o = 1'b0;
    wb_we_o = 1'b0;
    wb_adr_o = 8'h00;
    wb_sel_o = 4'hF;
    wb_dat_o = 32'h00000000;
  end

  // One transfer; request held until ack is sampled, no cycle count assumed
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] v,
                      output logic [31:0] r);
    @(posedge clk_i);
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o <= w;
    wb_adr_o <= a;
    wb_dat_o <= v;
    do @(posedge clk_i); while (wb_ack_i !== 1'b1);
    r = wb_dat_i;
    // Release; stale write data inverted so nothing leans on it
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
    wb_dat_o <= ~v;
  endtask : xfer
endmodule : ebp_bus_master

// ---- bench/tb_ebp_top.sv ----
`timescale 1ns/1ns
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin errors++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end
module tb_ebp_top;
  import ebp_pkg::*;
  // Expected read answer, masked
  typedef struct packed {logic [7:0] adr; logic [31:0] exp; logic [31:0] msk;} ebp_note_s;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc, stb, we, ack, irq;
  logic intr = 1'b0;
  logic recov = 1'b0;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dw, dr, d;
  logic [31:0] pw [2];
  ebp_note_s notes [$];
  ebp_note_s n;
  int errors = 0;
  int checks = 0;

  // Free running 100 MHz clock
  always #5 clk_i = ~clk_i;

  ebp_top #(.NBLK(4)) i_ebp_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw),
    .wb_dat_o(dr), .wb_ack_o(ack), .init_interrupted_i(intr),
    .init_recovered_i(recov), .prog_irq_o(irq));
  ebp_bus_master i_ebp_bus_master (.clk_i(clk_i), .wb_cyc_o(cyc), .wb_stb_o(stb),
    .wb_we_o(we), .wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(dw), .wb_dat_i(dr),
    .wb_ack_i(ack));

  // Watcher: every read answer takes the oldest note
  always @(negedge clk_i) begin
    if (ack === 1'b1 && we === 1'b0) begin
      n = notes.pop_front();
      if (n.msk != 32'h0) `CHK($sformatf("reg %h", n.adr), n.exp & n.msk, dr & n.msk)
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    i_ebp_bus_master.xfer(1'b1, a, v, d);
  endtask : wr
  // Read with a note; a zero mask means poll only
  task automatic chk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    notes.push_back('{a, e, m});
    i_ebp_bus_master.xfer(1'b0, a, 32'h0, d);
  endtask : chk
  // Software must see busy clear before the next write
  task automatic wait_idle;
    do chk(EBP_OFF_STATUS, 32'h0, 32'h0); while (d[EBP_ST_BUSY] !== 1'b0);
  endtask : wait_idle
  task automatic prot(input logic [1:0] b, input logic [31:0] v);
    wr(EBP_OFF_BLKSEL, {30'h0, b});
    wr(EBP_OFF_PROT, v);
    wait_idle(); // A protection write runs the engine
  endtask : prot
  // Write access check; denied flag compared, engine drained if started
  task automatic acc(input logic [1:0] b, input logic pv, input logic den);
    wr(EBP_OFF_STATUS, 32'h11);
    wr(EBP_OFF_ACCESS, {1'b1, pv, 28'h0, b});
    chk(EBP_OFF_STATUS, {31'h0, den}, 32'h1);
    wait_idle();
  endtask : acc
  task automatic do_reset;
    rst_i <= 1'b1;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
  endtask : do_reset
  task automatic close_out;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out

  // Hang guard, far beyond the several hundred cycles expected
  initial begin
    #500000;
    errors++;
    close_out();
  end

  initial begin
    void'($urandom(17979));
    pw[0] = $urandom() & 32'h7FFFFFFF;
    pw[1] = $urandom() & 32'h7FFFFFFF;
    do_reset();
    chk(EBP_OFF_INIT, {30'h0, EBP_INIT_OK}, 32'h3);
    chk(8'h3C, 32'h0, 32'hFFFFFFFF);
    intr <= 1'b1;
    do_reset();
    chk(EBP_OFF_INIT, {30'h0, EBP_INIT_ERROR}, 32'h3);
    intr <= 1'b0;
    do_reset();
    $display("init test done");
    // Each level on block 1 with no password, block 0 open
    for (int l = 0; l < 3; l++) begin
      prot(2'd1, l);
      acc(2'd1, 1'b1, l != 0);
    end
    prot(2'd2, 32'h8);
    acc(2'd2, 1'b0, 1'b1);
    acc(2'd2, 1'b1, 1'b0);
    prot(2'd2, 32'h0);
    prot(2'd0, 32'h8);
    acc(2'd2, 1'b0, 1'b1);
    prot(2'd0, 32'h0);
    $display("level test done");
    // Engine phases, read while busy, masked interrupt
    wr(EBP_OFF_INTEN, 32'h0);
    wr(EBP_OFF_ACCESS, 32'hC0000003);
    chk(EBP_OFF_STATUS, 32'hA, 32'hA);
    wr(EBP_OFF_ACCESS, 32'h1);
    chk(EBP_OFF_ACCESS, 32'h0, 32'h0);
    do chk(EBP_OFF_STATUS, 32'h0, 32'h0); while (d[EBP_ST_ERASE] !== 1'b1 && d[3] === 1'b1);
    chk(EBP_OFF_STATUS, 32'hC, 32'hE);
    wait_idle();
    chk(EBP_OFF_STATUS, 32'h10, 32'h1E);
    repeat (3) @(negedge clk_i);
    `CHK("irq", 1'b0, irq)
    chk(EBP_OFF_INTST, 32'h0, 32'h1);
    wr(EBP_OFF_INTEN, 32'h1);
    repeat (3) @(negedge clk_i);
    `CHK("irq", 1'b1, irq)
    chk(EBP_OFF_INTST, 32'h1, 32'h1);
    wr(EBP_OFF_INTST, 32'h1);
    repeat (3) @(negedge clk_i);
    `CHK("irq", 1'b0, irq)
    $display("engine test done");
    // Password on block 1 under the no-access level
    prot(2'd1, 32'h1);
    wr(EBP_OFF_PWD, pw[0]);
    wr(EBP_OFF_PWD, pw[1]);
    wr(EBP_OFF_CTRL, 32'h0);
    chk(EBP_OFF_LOCK, 32'h3, 32'h3);
    acc(2'd1, 1'b1, 1'b0);
    wr(EBP_OFF_LOCK, 32'h1);
    chk(EBP_OFF_LOCK, 32'h2, 32'h3);
    acc(2'd1, 1'b1, 1'b1);
    wr(EBP_OFF_PWD, pw[0] ^ 32'h1);
    wr(EBP_OFF_PWD, pw[1]);
    wr(EBP_OFF_UNLOCK, 32'h0);
    chk(EBP_OFF_LOCK, 32'h2, 32'h3);
    wr(EBP_OFF_PWD, pw[0]);
    wr(EBP_OFF_PWD, EBP_PWD_ILLEGAL);
    wr(EBP_OFF_PWD, pw[1]);
    wr(EBP_OFF_UNLOCK, 32'h0);
    chk(EBP_OFF_LOCK, 32'h3, 32'h3);
    wr(EBP_OFF_STATUS, 32'h11);
    wr(EBP_OFF_PWD, pw[0]);
    wr(EBP_OFF_CTRL, 32'h0);
    chk(EBP_OFF_STATUS, 32'h1, 32'h1);
    wr(EBP_OFF_LOCK, 32'h1);
    $display("password test done");
    // Locked block 0 closes the rest
    wr(EBP_OFF_BLKSEL, 32'h0);
    wr(EBP_OFF_PWD, pw[1]);
    wr(EBP_OFF_CTRL, 32'h0);
    wr(EBP_OFF_LOCK, 32'h1);
    acc(2'd2, 1'b1, 1'b1);
    wr(EBP_OFF_PWD, pw[1]);
    wr(EBP_OFF_UNLOCK, 32'h0);
    acc(2'd2, 1'b1, 1'b0);
    acc(2'd1, 1'b1, 1'b1);
    do_reset();
    wr(EBP_OFF_BLKSEL, 32'h1);
    chk(EBP_OFF_LOCK, 32'h0, 32'h1);
    $display("global test done");
    close_out();
  end
endmodule : tb_ebp_top

// ---- hdl/ebp_pkg.sv ----
package ebp_pkg;

  // Register byte offsets
  localparam logic [7:0] EBP_OFF_CTRL = 8'h00;
  localparam logic [7:0] EBP_OFF_STATUS = 8'h04;
  localparam logic [7:0] EBP_OFF_BLKSEL = 8'h08;
  localparam logic [7:0] EBP_OFF_PROT = 8'h0C;
  localparam logic [7:0] EBP_OFF_PWD = 8'h10;
  localparam logic [7:0] EBP_OFF_UNLOCK = 8'h14;
  localparam logic [7:0] EBP_OFF_LOCK = 8'h18;
  localparam logic [7:0] EBP_OFF_ACCESS = 8'h1C;
  localparam logic [7:0] EBP_OFF_INTEN = 8'h20;
  localparam logic [7:0] EBP_OFF_INTST = 8'h24;
  localparam logic [7:0] EBP_OFF_INIT = 8'h28;

  // Protection field layout
  localparam int EBP_PROT_LVL_LSB = 0;
  localparam int EBP_PROT_PRIV_BIT = 3;
  localparam logic [2:0] EBP_LVL_RW_LRO = 3'h0;
  localparam logic [2:0] EBP_LVL_NA = 3'h1;
  localparam logic [2:0] EBP_LVL_RO = 3'h2;

  // Status bit positions
  localparam int EBP_ST_DENIED = 0;
  localparam int EBP_ST_COPY = 1;
  localparam int EBP_ST_ERASE = 2;
  localparam int EBP_ST_BUSY = 3;
  localparam int EBP_ST_RDW = 4;

  // Access request fields in the ACCESS register
  localparam int EBP_ACC_WE_BIT = 31;
  localparam int EBP_ACC_PRIV_BIT = 30;

  // Init result codes
  localparam logic [1:0] EBP_INIT_OK = 2'h1;
  localparam logic [1:0] EBP_INIT_ERROR = 2'h2;

  // Password words and the all-ones illegal word
  localparam int EBP_PWD_WORDS = 3;
  localparam logic [31:0] EBP_PWD_ILLEGAL = 32'hFFFFFFFF;

  // Programming engine timing
  localparam int EBP_COPY_NS = 100;
  localparam int EBP_ERASE_NS = 80;
  localparam int EBP_CLK_NS = 10;
  localparam int EBP_COPY_CYC = (EBP_COPY_NS + EBP_CLK_NS - 1) / EBP_CLK_NS;
  localparam int EBP_ERASE_CYC = (EBP_ERASE_NS + EBP_CLK_NS - 1) / EBP_CLK_NS;

  // Programming engine states
  typedef enum logic [1:0] {EBP_IDLE, EBP_COPY, EBP_ERASE} ebp_pstate_e;

  // Decision of one access check
  typedef struct packed {
    logic rd_ok;
    logic wr_ok;
  } ebp_perm_s;

endpackage : ebp_pkg

// ---- hdl/ebp_prog_engine.sv ----
`timescale 1ns/1ns
// Programming engine: copy into buffer, then erase buffer
module ebp_prog_engine
  import ebp_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Start pulse and status
  input wire logic start_i,
  output logic copy_o,
  output logic erase_o,
  output logic busy_o
);

  ebp_pstate_e state_reg, state_next;
  logic [7:0] cnt_reg, cnt_next; // Phase cycle counter

  // Next state
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    unique case (state_reg)
      EBP_IDLE: begin
        if (start_i) begin
          state_next = EBP_COPY;
          cnt_next = 8'(EBP_COPY_CYC - 1);
        end
      end
      EBP_COPY: begin
        if (cnt_reg == 8'h00) begin
          state_next = EBP_ERASE;
          cnt_next = 8'(EBP_ERASE_CYC - 1);
        end else begin
          cnt_next = cnt_reg - 8'h01;
        end
      end
      EBP_ERASE: begin
        if (cnt_reg == 8'h00) begin
          state_next = EBP_IDLE;
        end else begin
          cnt_next = cnt_reg - 8'h01;
        end
      end
      default: state_next = EBP_IDLE;
    endcase
  end

  // Registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= EBP_IDLE;
      cnt_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
    end
  end

  // Status straight from state
  assign copy_o = (state_reg == EBP_COPY);
  assign erase_o = (state_reg == EBP_ERASE);
  assign busy_o = (state_reg != EBP_IDLE);

endmodule : ebp_prog_engine

// ---- hdl/ebp_top.sv ----
`timescale 1ns/1ns
// Summary of operation
// - Block 0 protection is global for all
// - Each block has locked and unlocked states
// - Unlock only by matching committed password
// - Locked block 0 hides all other blocks
// - Block 0 unlocked: others follow own settings ORed with block 0
// - Privileged-only blocks refuse user accesses
// - RW level: locked with password reads only
// - No-access level: only unlocked password allows
// - Read-only level: locked password refuses all
// - Init reports error after unrecovered interruption
// - Init reports ready when nothing interrupted
// - Maskable programming interrupt with readable status
// - Denied write flags error and is refused
// - Copy-buffer transfer status while copying
// - Copy-buffer erase status while erasing
// - Busy bit set during any engine operation
// - Password stored once; later attempts rejected
// - Password words never all ones; 1-3 words
// - Block N protection is OR with block 0
// - Read during write flags read-during-write
module ebp_top
  import ebp_pkg::*;
#(
  parameter int NBLK = 4
)(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Power-on recovery inputs (from storage, same clock)
  input wire logic init_interrupted_i,
  input wire logic init_recovered_i,
  // Programming interrupt
  output logic prog_irq_o
);

  localparam int BW = $clog2(NBLK);

  // Per-block state
  logic [3:0] prot_reg [NBLK], prot_next [NBLK]; // Level and privileged bit
  logic [NBLK-1:0] haspwd_reg, haspwd_next; // Password committed
  logic [NBLK-1:0] unlk_reg, unlk_next; // Unlocked state
  logic [31:0] pwd_reg [NBLK][EBP_PWD_WORDS]; // Stored words
  logic [31:0] pwd_next [NBLK][EBP_PWD_WORDS];
  logic [1:0] plen_reg [NBLK], plen_next [NBLK]; // Password length minus 1
  // Staging and control
  logic [BW-1:0] sel_reg, sel_next; // Block selected by software
  logic [31:0] stage_reg [EBP_PWD_WORDS], stage_next [EBP_PWD_WORDS];
  logic [1:0] scnt_reg, scnt_next; // Staged words
  logic denied_reg, denied_next; // Sticky write error
  logic rdw_reg, rdw_next; // Sticky read-during-write
  logic inten_reg, inten_next; // Interrupt enable
  logic irqpend_reg, irqpend_next; // Programming done pending
  logic [1:0] init_reg, init_next; // Init result
  logic init_done_reg, init_done_next;
  logic [31:0] dat_reg, dat_next;
  logic ack_reg, ack_next;
  logic irq_reg, irq_next;
  logic busy_d_reg;
  logic [7:0] bcnt_reg, bcnt_next; // Busy cycles seen, for the length check
  // Engine
  logic eng_start, eng_copy, eng_erase, eng_busy;

  ebp_prog_engine i_ebp_prog_engine (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(eng_start),
    .copy_o(eng_copy),
    .erase_o(eng_erase),
    .busy_o(eng_busy)
  );

  // Access decision for one block and mode
  function automatic ebp_perm_s perm_f(input logic [3:0] own, input logic [3:0] glob,
      input logic haspwd, input logic unlk, input logic priv, input logic gate_ok);
    logic [3:0] eff;
    logic locked;
    ebp_perm_s p;
    eff = own | glob;
    locked = haspwd & ~unlk;
    p.rd_ok = 1'b0;
    p.wr_ok = 1'b0;
    unique case (eff[2:0])
      EBP_LVL_RW_LRO: begin
        p.rd_ok = 1'b1;
        p.wr_ok = ~locked;
      end
      EBP_LVL_NA: begin
        p.rd_ok = haspwd & unlk;
        p.wr_ok = haspwd & unlk;
      end
      EBP_LVL_RO: begin
        p.rd_ok = ~locked;
      end
      default: ;
    endcase
    if ((eff[EBP_PROT_PRIV_BIT] && !priv) || !gate_ok) begin
      p = '0;
    end
    return p;
  endfunction : perm_f

  // Password compare of staged words against block
  function automatic logic pwd_match_f(input logic [BW-1:0] b);
    logic m;
    m = (scnt_reg == plen_reg[b] + 2'h1);
    for (int i = 0; i < EBP_PWD_WORDS; i++) begin
      if (i <= int'(plen_reg[b]) && stage_reg[i] != pwd_reg[b][i]) m = 1'b0;
    end
    return m;
  endfunction : pwd_match_f

  logic req, gate_ok, blk0_sel;
  ebp_perm_s acc;
  logic [BW-1:0] acc_blk;
  assign req = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign blk0_sel = (sel_reg == '0);
  assign gate_ok = blk0_sel | ~haspwd_reg[0] | unlk_reg[0];
  assign acc_blk = wb_dat_i[BW-1:0];
  assign acc = perm_f(prot_reg[acc_blk], (acc_blk == '0) ? 4'h0 : prot_reg[0],
      haspwd_reg[acc_blk], unlk_reg[acc_blk], wb_dat_i[EBP_ACC_PRIV_BIT],
      (acc_blk == '0) | ~haspwd_reg[0] | unlk_reg[0]);

  // Next-state logic for the register file
  always_comb begin
    prot_next = prot_reg;
    haspwd_next = haspwd_reg;
    unlk_next = unlk_reg;
    pwd_next = pwd_reg;
    plen_next = plen_reg;
    sel_next = sel_reg;
    stage_next = stage_reg;
    scnt_next = scnt_reg;
    denied_next = denied_reg;
    rdw_next = rdw_reg;
    inten_next = inten_reg;
    irqpend_next = irqpend_reg | (busy_d_reg & ~eng_busy); // Done edge
    bcnt_next = eng_busy ? bcnt_reg + 8'h01 : 8'h00; // Restarts at every idle cycle
    init_next = init_reg;
    init_done_next = 1'b1;
    dat_next = 32'h00000000;
    ack_next = req;
    eng_start = 1'b0;
    if (!init_done_reg) begin
      if (init_interrupted_i && !init_recovered_i) init_next = EBP_INIT_ERROR;
      else init_next = EBP_INIT_OK;
    end
    if (req && wb_we_i) begin
      unique case (wb_adr_i)
        EBP_OFF_BLKSEL: sel_next = wb_dat_i[BW-1:0];
        EBP_OFF_PROT: begin
          if (!gate_ok || (haspwd_reg[sel_reg] && !unlk_reg[sel_reg])) begin
            denied_next = 1'b1;
          end else if (eng_busy) begin
            rdw_next = rdw_reg; // Refused while busy
          end else begin
            prot_next[sel_reg] = wb_dat_i[3:0];
            eng_start = 1'b1;
          end
        end
        EBP_OFF_PWD: begin
          if (wb_dat_i != EBP_PWD_ILLEGAL && scnt_reg < 2'(EBP_PWD_WORDS)) begin
            stage_next[scnt_reg] = wb_dat_i;
            scnt_next = scnt_reg + 2'h1;
          end
        end
        EBP_OFF_CTRL: begin
          // Commit staged password once
          if (haspwd_reg[sel_reg] || !gate_ok || scnt_reg == 2'h0 || eng_busy) begin
            denied_next = 1'b1;
          end else begin
            haspwd_next[sel_reg] = 1'b1;
            unlk_next[sel_reg] = 1'b1;
            plen_next[sel_reg] = scnt_reg - 2'h1;
            for (int i = 0; i < EBP_PWD_WORDS; i++) pwd_next[sel_reg][i] = stage_reg[i];
            eng_start = 1'b1;
          end
          scnt_next = 2'h0;
        end
        EBP_OFF_UNLOCK: begin
          if (haspwd_reg[sel_reg] && pwd_match_f(sel_reg)) unlk_next[sel_reg] = 1'b1;
          scnt_next = 2'h0;
        end
        EBP_OFF_LOCK: begin
          if (haspwd_reg[sel_reg]) unlk_next[sel_reg] = 1'b0;
        end
        EBP_OFF_ACCESS: begin
          // Data access check; reads during write flag
          if (wb_dat_i[EBP_ACC_WE_BIT]) begin
            if (!acc.wr_ok) denied_next = 1'b1;
            else if (!eng_busy) eng_start = 1'b1;
          end else if (eng_busy) begin
            rdw_next = 1'b1;
          end
        end
        EBP_OFF_INTEN: inten_next = wb_dat_i[0];
        EBP_OFF_STATUS: begin
          denied_next = denied_reg & ~wb_dat_i[EBP_ST_DENIED];
          rdw_next = rdw_reg & ~wb_dat_i[EBP_ST_RDW];
        end
        // Write one clears; a done edge in the same cycle still sets
        EBP_OFF_INTST: irqpend_next = (irqpend_reg & ~wb_dat_i[0]) | (busy_d_reg & ~eng_busy);
        default: ;
      endcase
    end else if (req) begin
      unique case (wb_adr_i)
        EBP_OFF_STATUS: dat_next = {27'h0, rdw_reg, eng_busy, eng_erase, eng_copy, denied_reg};
        EBP_OFF_BLKSEL: dat_next = 32'(sel_reg);
        EBP_OFF_PROT: dat_next = gate_ok ? {28'h0, prot_reg[sel_reg]} : 32'h00000000;
        EBP_OFF_LOCK: dat_next = {30'h0, haspwd_reg[sel_reg], unlk_reg[sel_reg]};
        EBP_OFF_INTEN: dat_next = {31'h0, inten_reg};
        EBP_OFF_INTST: dat_next = {31'h0, irqpend_reg & inten_reg};
        EBP_OFF_INIT: dat_next = {30'h0, init_reg};
        default: dat_next = 32'h00000000;
      endcase
    end
    irq_next = irqpend_next & inten_next;
  end

  // Register file
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int b = 0; b < NBLK; b++) begin
        prot_reg[b] <= 4'h0;
        plen_reg[b] <= 2'h0;
        for (int i = 0; i < EBP_PWD_WORDS; i++) pwd_reg[b][i] <= 32'h00000000;
      end
      for (int i = 0; i < EBP_PWD_WORDS; i++) stage_reg[i] <= 32'h00000000;
      haspwd_reg <= '0;
      unlk_reg <= '0;
      sel_reg <= '0;
      scnt_reg <= 2'h0;
      denied_reg <= 1'b0;
      rdw_reg <= 1'b0;
      inten_reg <= 1'b0;
      irqpend_reg <= 1'b0;
      init_reg <= 2'h0;
      init_done_reg <= 1'b0;
      dat_reg <= 32'h00000000;
      ack_reg <= 1'b0;
      irq_reg <= 1'b0;
      busy_d_reg <= 1'b0;
      bcnt_reg <= 8'h00;
    end else begin
      prot_reg <= prot_next;
      plen_reg <= plen_next;
      pwd_reg <= pwd_next;
      stage_reg <= stage_next;
      haspwd_reg <= haspwd_next;
      unlk_reg <= unlk_next;
      sel_reg <= sel_next;
      scnt_reg <= scnt_next;
      denied_reg <= denied_next;
      rdw_reg <= rdw_next;
      inten_reg <= inten_next;
      irqpend_reg <= irqpend_next;
      init_reg <= init_next;
      init_done_reg <= init_done_next;
      dat_reg <= dat_next;
      ack_reg <= ack_next;
      irq_reg <= irq_next;
      busy_d_reg <= eng_busy;
      bcnt_reg <= bcnt_next;
    end
  end

  assign wb_dat_o = dat_reg;
  assign wb_ack_o = ack_reg;
  assign prog_irq_o = irq_reg;

  // Checks
  a_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i) // bus
    wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
  a_denied_write_sets: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && wb_we_i && wb_adr_i == EBP_OFF_ACCESS && wb_dat_i[EBP_ACC_WE_BIT] && !acc.wr_ok)
    |=> denied_reg) else $error("denied write not flagged");
  a_denied_no_start: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && wb_we_i && wb_adr_i == EBP_OFF_ACCESS && !acc.wr_ok) |-> !eng_start)
    else $error("denied write started engine");
  a_pwd_once: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && wb_we_i && wb_adr_i == EBP_OFF_CTRL && haspwd_reg[sel_reg]) |=> denied_reg)
    else $error("second password not rejected");
  a_busy_length: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(eng_busy) |-> bcnt_reg == 8'(EBP_COPY_CYC + EBP_ERASE_CYC))
    else $error("busy length wrong");
  a_copy_then_erase: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(eng_copy) |-> eng_erase && eng_busy) else $error("erase not after copy");
  a_rdw_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && wb_we_i && wb_adr_i == EBP_OFF_ACCESS && !wb_dat_i[EBP_ACC_WE_BIT] && eng_busy)
    |=> rdw_reg) else $error("read during write missed");
  a_irq_masked: assert property (@(posedge clk_i) disable iff (rst_i)
    prog_irq_o |-> $past(inten_next)) else $error("irq while disabled");
  a_gate_blk0: assert property (@(posedge clk_i) disable iff (rst_i)
    (haspwd_reg[0] && !unlk_reg[0] && acc_blk != '0) |-> !acc.rd_ok && !acc.wr_ok)
    else $error("locked block 0 did not gate");
  a_init_result: assert property (@(posedge clk_i) disable iff (rst_i)
    (!init_done_reg && init_interrupted_i && !init_recovered_i) |=> init_reg == EBP_INIT_ERROR)
    else $error("init error not reported");
  c_commit: cover property (@(posedge clk_i) $rose(haspwd_reg[0]));
  c_unlock: cover property (@(posedge clk_i) haspwd_reg[1] && $rose(unlk_reg[1]));
  c_irq: cover property (@(posedge clk_i) $rose(prog_irq_o));
  c_rdw: cover property (@(posedge clk_i) $rose(rdw_reg));

endmodule : ebp_top
